// *** hdl/lds_fifo.v ***
// Synchronous FIFO with valid/ready on both sides, registered read data.
// Single clock domain; reset asynchronous active low.
`timescale 1ns/10ps
`default_nettype none
module lds_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
)(
  input wire i_clk, // Clock
  input wire i_rst_n, // Async reset, low
  input wire [WIDTH-1:0] i_wdata, // Write data
  input wire i_wvalid, // Write request
  output wire o_wready, // Not full
  output reg [WIDTH-1:0] o_rdata, // Read data
  output wire o_rvalid, // Head valid
  input wire i_rready // Head taken
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_ff;
  reg [AW:0] rp_ff;
  reg hv_ff;
  wire [AW:0] cnt = wp_ff - rp_ff;
  wire full = (cnt == DEPTH);
  wire stored = (cnt != {(AW+1){1'b0}});
  wire pop = stored && (!hv_ff || i_rready);
  assign o_wready = !full;
  assign o_rvalid = hv_ff;
  // Storage write; no reset so it maps to RAM
  always @(posedge i_clk)
  begin
    if (i_wvalid && !full)
      mem[wp_ff[AW-1:0]] <= i_wdata;
  end
  // Pointers and output register stage
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_ff <= {(AW+1){1'b0}};
      rp_ff <= {(AW+1){1'b0}};
      hv_ff <= 1'b0;
      o_rdata <= {WIDTH{1'b0}};
    end
    else
    begin
      if (i_wvalid && !full)
        wp_ff <= wp_ff + 1'b1;
      if (pop)
      begin
        rp_ff <= rp_ff + 1'b1;
        o_rdata <= mem[rp_ff[AW-1:0]];
        hv_ff <= 1'b1;
      end
      else if (i_rready)
        hv_ff <= 1'b0;
    end
  end
endmodule // lds_fifo
`default_nettype wire

// *** hdl/lds_map.vh ***
// Constants for the LED driver two-wire slave front end.
// Included by the slave design file and the bench files; definitions only.
`ifndef LDS_MAP_VH
`define LDS_MAP_VH
`define LDS_BASE_ADDR 7'h00
`define LDS_CMD_DIGIT0 8'h01
`define LDS_CMD_DIGIT7 8'h08
`define LDS_CMD_DECODE 8'h09
`define LDS_CMD_INTENS 8'h0A
`define LDS_CMD_SCANLIM 8'h0B
`define LDS_CMD_SHUTDN 8'h0C
`define LDS_CMD_SELFADR 8'h2D
`define LDS_CMD_FEATURE 8'h0E
`define LDS_CMD_DISPTST 8'h0F
`define LDS_RST_DECODE 8'h00
`define LDS_RST_INTENS 8'h00
`define LDS_RST_SCANLIM 8'h00
`define LDS_RST_SHUTDN 8'h00
`define LDS_RST_FEATURE 8'h00
`define LDS_RST_DISPTST 8'h00
`define LDS_SHD_RUN_BIT 0
`define LDS_SHD_KEEP_BIT 7
`define LDS_FIFO_DEPTH 32
`endif

// *** hdl/lds_slave.v ***
// Two-wire bus slave and command decoder of an LED display driver.
// Assumes SCL and SDA arrive asynchronously and are oversampled at 20 MHz.
// Functional notes
// [R1] Slave only: master drives clock, START and STOP.
// [R2] Bus rates up to 3.4 MHz high-speed mode supported.
// [R3] Master starts only when both lines are idle high.
// [R4] Data stable while clock high; changes then are conditions.
// [R5] START is SDA fall with SCL high; STOP is SDA rise.
// [R6] Bytes plus ninth acknowledge bit; byte count unlimited.
// [R7] Acknowledger holds SDA low through the ninth clock high.
// [R8] Master NACKs last read byte; device then releases SDA.
// [R9] Write: address and every data byte are acknowledged.
// [R10] Read: device sends bytes after acknowledged address.
// [R11] First byte is address, MSB first; last bit one means read.
// [R12] Address is all zeros after power-up.
// [R13] Two low address bits are select bits set by self-address.
// [R14] Shorted node gives zero, open node gives one.
// [R15] Low bit from key return with G node, high with F.
// [R16] Master issues one self-address command after each startup.
// [R17] Acknowledge after matching address and direction bit.
// [R18] Command byte is bits fifteen to eight of received word.
// [R19] Power-up resets registers, blanks display, enters shutdown.
// [R20] Defaults: one digit scanned, decoder off, minimum intensity.
// [R21] Shutdown register write with bit zero clear enters shutdown; digits retained.
// [R22] Shutdown write with bit seven clear zeroes feature register.
// [R23] Bit zero one runs, zero shuts down; bit seven keeps features.
// [R24] Address mismatch: SDA released until next START.
`timescale 1ns/10ps
`default_nettype none
`include "lds_map.vh"
module lds_slave #(
  parameter FIFO_DEPTH = `LDS_FIFO_DEPTH
)(
  input wire I_CLOCK, // 20 MHz clock
  input wire I_RESETN, // Async reset, low
  input wire I_SCL, // Bus clock pin
  input wire I_SDA, // Bus data pin in
  output wire O_SDA, // Bus data out, always 0
  output reg O_SDA_OE, // High while pulling SDA low
  input wire I_KEY_RETURN_FIRST_SEG_G, // Node level, low when shorted
  input wire I_KEY_RETURN_FIRST_SEG_F, // Node level, low when shorted
  input wire [7:0] I_READ_DATA, // Byte returned on reads
  output wire [15:0] O_WR_WORD, // Received command and data word
  output wire O_WR_VALID, // Word available
  input wire I_WR_READY, // Word consumed
  output reg [7:0] O_LAST_CMD, // Last command byte (read pointer)
  output reg [6:0] O_DEV_ADDR, // Current slave address
  output reg O_SHUTDOWN, // Display in shutdown
  output reg O_BLANK, // Display blanked
  output reg [7:0] O_DECODE, // Decode enable
  output reg [7:0] O_INTENSITY, // Global intensity
  output reg [7:0] O_SCAN_LIMIT, // Scan limit
  output reg [7:0] O_FEATURE, // Feature register
  output reg [7:0] O_DISP_TEST // Display test
);
  // Transfer states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WRITE = 3'h2;
  localparam ST_READ = 3'h3;
  localparam ST_SKIP = 3'h4;
  // Pointer width follows the depth so a deeper FIFO still wraps right
  localparam FIFO_AW = $clog2(FIFO_DEPTH);
  // Two-flop synchronisers then a history flop for edges
  reg scl_m_ff, scl_s_ff, scl_d_ff;
  reg sda_m_ff, sda_s_ff, sda_d_ff;
  always @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_m_ff <= I_SCL;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= I_SDA;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end
  // Key nodes are pins too; two flops before the address logic reads
  // them, reset to the open level so nothing looks shorted early
  reg key_g_m_ff, key_g_s_ff, key_f_m_ff, key_f_s_ff;
  always @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      key_g_m_ff <= 1'b1;
      key_g_s_ff <= 1'b1;
      key_f_m_ff <= 1'b1;
      key_f_s_ff <= 1'b1;
    end
    else
    begin
      key_g_m_ff <= I_KEY_RETURN_FIRST_SEG_G;
      key_g_s_ff <= key_g_m_ff;
      key_f_m_ff <= I_KEY_RETURN_FIRST_SEG_F;
      key_f_s_ff <= key_f_m_ff;
    end
  end
  // At 20 MHz a 3.4 MHz clock gives under 6 samples per period; a
  // faster system clock is needed for full high-speed margin.
  wire scl_rise = scl_s_ff && !scl_d_ff; // see [R2]
  wire scl_fall = !scl_s_ff && scl_d_ff;
  // Conditions only when SDA moves with SCL high, see [R4]
  wire start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff; // see [R5]
  wire stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff; // see [R5]
  // Serial engine state
  reg [2:0] st_ff;
  reg [3:0] bit_ff;
  reg [7:0] sh_ff;
  reg ack_ph_ff;
  reg nack_ff;
  reg [1:0] byte_ff;
  reg [7:0] cmd_ff;
  reg self_ff;
  // Received word heading for the FIFO
  reg [15:0] word_ff;
  reg push_ff;
  // Base code; only its upper five bits survive self-addressing
  wire [6:0] base_addr = `LDS_BASE_ADDR;
  function addr_match;
    input [6:0] rx;
    input [6:0] own;
    begin
      addr_match = (rx == own);
    end
  endfunction
  // Serial engine; only reacts to master-made edges, see [R1]
  always @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      st_ff <= ST_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      ack_ph_ff <= 1'b0;
      nack_ff <= 1'b0;
      byte_ff <= 2'h0;
      cmd_ff <= 8'h00;
      word_ff <= 16'h0000;
      push_ff <= 1'b0;
      O_SDA_OE <= 1'b0;
      O_LAST_CMD <= 8'h00;
    end
    else
    begin
      push_ff <= 1'b0;
      if (start_det)
      begin
        // Repeated START also restarts address phase, see [R11]
        st_ff <= ST_ADDR;
        bit_ff <= 4'h0;
        ack_ph_ff <= 1'b0;
        byte_ff <= 2'h0;
        O_SDA_OE <= 1'b0;
      end
      else if (stop_det)
      begin
        st_ff <= ST_IDLE;
        O_SDA_OE <= 1'b0;
      end
      else
      begin
        case (st_ff)
          ST_IDLE, ST_SKIP:
          begin
            O_SDA_OE <= 1'b0; // see [R24]
          end
          ST_ADDR, ST_WRITE:
          begin
            if (scl_rise && !ack_ph_ff)
            begin
              sh_ff <= {sh_ff[6:0], sda_s_ff}; // MSB first, see [R11]
              bit_ff <= bit_ff + 4'h1;
            end
            if (scl_fall && !ack_ph_ff && bit_ff == 4'h8)
            begin
              ack_ph_ff <= 1'b1;
              bit_ff <= 4'h0;
              if (st_ff == ST_ADDR)
              begin
                if (addr_match(sh_ff[7:1], O_DEV_ADDR))
                  O_SDA_OE <= 1'b1; // see [R17]
                else
                  st_ff <= ST_SKIP; // see [R24]
              end
              else
                O_SDA_OE <= 1'b1; // Every data byte acked, see [R9]
              if (st_ff == ST_WRITE)
              begin
                // Two bytes make a word, command first, see [R18]
                if (byte_ff == 2'h0)
                begin
                  cmd_ff <= sh_ff;
                  O_LAST_CMD <= sh_ff;
                  byte_ff <= 2'h1;
                end
                else
                begin
                  word_ff <= {cmd_ff, sh_ff};
                  push_ff <= 1'b1;
                end
              end
            end
            else if (scl_fall && ack_ph_ff)
            begin
              // Ack held through whole ninth high, see [R7]
              ack_ph_ff <= 1'b0;
              O_SDA_OE <= 1'b0;
              if (st_ff == ST_ADDR)
              begin
                if (sh_ff[0])
                begin
                  st_ff <= ST_READ; // see [R10]
                  sh_ff <= I_READ_DATA;
                  O_SDA_OE <= !I_READ_DATA[7];
                  bit_ff <= 4'h1;
                end
                else
                  st_ff <= ST_WRITE; // see [R6]
              end
            end
          end
          // Slave transmits; master acks every byte but the last
          ST_READ:
          begin
            if (scl_fall && !ack_ph_ff)
            begin
              if (bit_ff == 4'h8)
              begin
                ack_ph_ff <= 1'b1;
                O_SDA_OE <= 1'b0; // Master acks, line released
              end
              else
              begin
                O_SDA_OE <= !sh_ff[3'h7 - bit_ff[2:0]];
                bit_ff <= bit_ff + 4'h1;
              end
            end
            else if (scl_rise && ack_ph_ff)
              nack_ff <= sda_s_ff;
            else if (scl_fall && ack_ph_ff)
            begin
              ack_ph_ff <= 1'b0;
              if (nack_ff)
              begin
                st_ff <= ST_SKIP; // Release for STOP, see [R8]
                O_SDA_OE <= 1'b0;
              end
              else
              begin
                sh_ff <= I_READ_DATA;
                O_SDA_OE <= !I_READ_DATA[7];
                bit_ff <= 4'h1;
              end
            end
          end
          default:
          begin
            st_ff <= ST_IDLE;
            O_SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end
  // Open drain: only ever drives low
  assign O_SDA = 1'b0;
  // Word FIFO decouples bus from register consumers; when full the
  // word is dropped since a slave here does not stretch the clock.
  lds_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RESETN),
    .i_wdata(word_ff),
    .i_wvalid(push_ff),
    .o_wready(), // Full only drops, never stalls
    .o_rdata(O_WR_WORD),
    .o_rvalid(O_WR_VALID),
    .i_rready(I_WR_READY)
  );
  // Control registers applied at push time
  wire [7:0] w_cmd = word_ff[15:8];
  wire [7:0] w_dat = word_ff[7:0];
  always @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_DEV_ADDR <= `LDS_BASE_ADDR; // see [R12]
      O_SHUTDOWN <= 1'b1; // see [R19]
      O_BLANK <= 1'b1; // see [R19]
      O_DECODE <= `LDS_RST_DECODE; // see [R20]
      O_INTENSITY <= `LDS_RST_INTENS; // see [R20]
      O_SCAN_LIMIT <= `LDS_RST_SCANLIM; // see [R20]
      O_FEATURE <= `LDS_RST_FEATURE;
      O_DISP_TEST <= `LDS_RST_DISPTST;
      self_ff <= 1'b0;
    end
    else if (push_ff)
    begin
      case (w_cmd)
        `LDS_CMD_DECODE: O_DECODE <= w_dat;
        `LDS_CMD_INTENS: O_INTENSITY <= w_dat;
        `LDS_CMD_SCANLIM: O_SCAN_LIMIT <= w_dat;
        `LDS_CMD_FEATURE: O_FEATURE <= w_dat;
        `LDS_CMD_DISPTST: O_DISP_TEST <= w_dat;
        `LDS_CMD_SHUTDN:
        begin
          O_SHUTDOWN <= !w_dat[`LDS_SHD_RUN_BIT]; // see [R21] [R23]
          O_BLANK <= !w_dat[`LDS_SHD_RUN_BIT];
          if (!w_dat[`LDS_SHD_KEEP_BIT])
            O_FEATURE <= `LDS_RST_FEATURE; // see [R22]
        end
        `LDS_CMD_SELFADR:
        begin
          // One-shot until reset; a late command cannot move a live address
          if (!self_ff)
          begin
            // Open node reads 1, shorted 0, see [R13] [R14] [R15]
            O_DEV_ADDR <= {base_addr[6:2], key_f_s_ff, key_g_s_ff};
            self_ff <= 1'b1; // see [R16]
          end
        end
        default:
        begin
          self_ff <= self_ff; // Digit writes live outside; retained, see [R21]
        end
      endcase
    end
  end
endmodule // lds_slave
`default_nettype wire

// *** tb/lds_bus_master.sv ***
// Behavioural two-wire bus master for the slave's pins.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module lds_bus_master (
  input wire logic i_clock, // Pacing clock
  input wire logic i_sda, // Resolved SDA
  output var logic o_scl, // Bus clock
  output var logic o_sda_pull // High pulls SDA low
);
  // Idle bus: both lines high
  initial
  begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // Eight clocks a phase, well over the slave's sync delay
  task automatic hold(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // Only from idle or after an acknowledge slot
  task automatic bus_start();
    o_sda_pull = 1'b0;
    hold(8);
    o_scl = 1'b1;
    hold(8);
    o_sda_pull = 1'b1;
    hold(8);
    o_scl = 1'b0;
    hold(2);
  endtask
  task automatic bus_stop();
    o_sda_pull = 1'b1;
    hold(8);
    o_scl = 1'b1;
    hold(8);
    o_sda_pull = 1'b0;
    hold(8);
  endtask
  // SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    o_sda_pull = !b;
    hold(8);
    o_scl = 1'b1;
    hold(4);
    r = i_sda;
    hold(4);
    o_scl = 1'b0;
    hold(2);
  endtask
  // MSB first, then SDA released for the acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Acknowledge all but the last byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // lds_bus_master
`default_nettype wire

// *** tb/lds_slave_assertions.sv ***
// Concurrent checks on the bus slave's ports.
// Assumes one clock domain; bound below.
`timescale 1ns/10ps
`default_nettype none
`include "lds_map.vh"
module lds_slave_chk #(
  parameter FIFO_DEPTH = 32
)(
  input wire logic I_CLOCK, // Clock
  input wire logic I_RESETN, // Reset, low
  input wire logic I_SCL, // Bus clock
  input wire logic I_KEY_RETURN_FIRST_SEG_G, // Low node
  input wire logic I_KEY_RETURN_FIRST_SEG_F, // High node
  input wire logic O_SDA, // Data out
  input wire logic O_SDA_OE, // Pull enable
  input wire logic [7:0] O_LAST_CMD, // Command
  input wire logic [6:0] O_DEV_ADDR, // Address
  input wire logic O_SHUTDOWN, // Shutdown
  input wire logic O_BLANK, // Blank
  input wire logic [7:0] O_DECODE, // Decode
  input wire logic [7:0] O_FEATURE // Features
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESETN);
  // No byte can have arrived yet, so no pull
  sequence seq_quiet;
    !O_SDA_OE [*3];
  endsequence
  sda_low_a: assert property (O_SDA == 1'b0)
    else $error("SDA output not low");
  reset_quiet_a: assert property ($rose(I_RESETN) |-> seq_quiet)
    else $error("SDA pulled after reset");
  reset_state_a: assert property ($rose(I_RESETN) |-> O_SHUTDOWN && O_BLANK && O_DEV_ADDR == 7'h00)
    else $error("Bad state after reset");
  pull_edge_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
    else $error("SDA pull moved with SCL high");
  shutdown_cmd_a: assert property ($changed(O_SHUTDOWN) |-> O_LAST_CMD == `LDS_CMD_SHUTDN && O_BLANK == O_SHUTDOWN)
    else $error("Shutdown moved without its command");
  feature_set_a: assert property ($changed(O_FEATURE) && O_FEATURE != 8'h00 |-> O_LAST_CMD == `LDS_CMD_FEATURE)
    else $error("Feature set without its command");
  addr_set_a: assert property ($changed(O_DEV_ADDR) |-> O_LAST_CMD == `LDS_CMD_SELFADR &&
    O_DEV_ADDR == {5'h00, I_KEY_RETURN_FIRST_SEG_F, I_KEY_RETURN_FIRST_SEG_G})
    else $error("Bad address update");
  decode_cmd_a: assert property ($changed(O_DECODE) |-> O_LAST_CMD == `LDS_CMD_DECODE)
    else $error("Decode moved without its command");
endmodule // lds_slave_chk
bind lds_slave lds_slave_chk #(.FIFO_DEPTH(FIFO_DEPTH)) lds_slave_chk_i (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
  .I_SCL(I_SCL), .I_KEY_RETURN_FIRST_SEG_G(I_KEY_RETURN_FIRST_SEG_G), .I_KEY_RETURN_FIRST_SEG_F(I_KEY_RETURN_FIRST_SEG_F),
  .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .O_LAST_CMD(O_LAST_CMD), .O_DEV_ADDR(O_DEV_ADDR), .O_SHUTDOWN(O_SHUTDOWN),
  .O_BLANK(O_BLANK), .O_DECODE(O_DECODE), .O_FEATURE(O_FEATURE));
`default_nettype wire

// *** tb/test_lds_slave.sv ***
// Bench for the LED driver bus slave.
// Assumes the master model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "lds_map.vh"
module test_lds_slave;
  logic clk, rst_n, key_g, key_f, ready;
  logic [7:0] rd_data;
  wire scl, pull, sda, sda_out, sda_oe, valid, shutdown, blank;
  wire [15:0] word;
  wire [7:0] last_cmd, decode, intens, scan, feature, disp_test;
  wire [6:0] dev_addr;
  int n_mismatch = 0;
  int num_checks = 0;
  // Pull-up: low while either party pulls
  assign sda = (sda_oe ? sda_out : 1'b1) & !pull;
  lds_bus_master lds_bus_master_i (.i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
  lds_slave lds_slave_i (.I_CLOCK(clk), .I_RESETN(rst_n), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_out),
    .O_SDA_OE(sda_oe), .I_KEY_RETURN_FIRST_SEG_G(key_g), .I_KEY_RETURN_FIRST_SEG_F(key_f), .I_READ_DATA(rd_data),
    .O_WR_WORD(word), .O_WR_VALID(valid), .I_WR_READY(ready), .O_LAST_CMD(last_cmd), .O_DEV_ADDR(dev_addr),
    .O_SHUTDOWN(shutdown), .O_BLANK(blank), .O_DECODE(decode), .O_INTENSITY(intens), .O_SCAN_LIMIT(scan),
    .O_FEATURE(feature), .O_DISP_TEST(disp_test));
  // 20 MHz
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One write transfer: address, command, data
  task automatic write_reg(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic e);
    logic k1, k2, k3;
    lds_bus_master_i.bus_start();
    lds_bus_master_i.send_byte({a, 1'b0}, k1);
    lds_bus_master_i.send_byte(c, k2);
    lds_bus_master_i.send_byte(d, k3);
    lds_bus_master_i.bus_stop();
    check("acks", {13'h0, e, e, e}, {13'h0, k1, k2, k3});
  endtask
  task automatic t_defaults();
    check("flags", 16'h0003, {14'h0, shutdown, blank});
    check("addr", 16'h0000, {9'h0, dev_addr});
    check("scan decode", 16'h0000, {scan, decode});
    check("intens feature", 16'h0000, {intens, feature});
    check("valid disp test", 16'h0000, {7'h0, valid, disp_test});
  endtask
  // Consumer stalled: storage plus the head register fill up, the next
  // word is dropped while the registers still move
  task automatic t_fifo();
    int cnt = 0;
    for (int i = 0; i <= `LDS_FIFO_DEPTH + 1; i++) write_reg(7'h00, `LDS_CMD_INTENS, 8'(i), 1'b1);
    check("intens", 16'(`LDS_FIFO_DEPTH + 1), {8'h0, intens});
    ready = 1'b1;
    repeat (300)
    begin
      if (valid)
      begin
        check("word", {`LDS_CMD_INTENS, 8'(cnt)}, word);
        cnt++;
      end
      @(negedge clk);
    end
    check("depth", 16'(`LDS_FIFO_DEPTH + 1), 16'(cnt));
  endtask
  task automatic t_shutdown();
    logic [7:0] codes [4] = '{8'h81, 8'h80, 8'h01, 8'h00};
    foreach (codes[i])
    begin
      write_reg(7'h00, `LDS_CMD_FEATURE, 8'h05, 1'b1);
      write_reg(7'h00, `LDS_CMD_SHUTDN, codes[i], 1'b1);
      check("shutdown blank", {14'h0, !codes[i][0], !codes[i][0]}, {14'h0, shutdown, blank});
      check("feature", codes[i][7] ? 16'h0005 : 16'h0000, {8'h0, feature});
    end
  endtask
  task automatic t_self_addr();
    write_reg(7'h00, `LDS_CMD_SELFADR, 8'h00, 1'b1);
    check("addr", 16'h0001, {9'h0, dev_addr});
    write_reg(7'h00, `LDS_CMD_SCANLIM, 8'h07, 1'b0);
    check("scan", 16'h0000, {8'h0, scan});
    write_reg(7'h01, `LDS_CMD_SCANLIM, 8'h07, 1'b1);
    check("scan", 16'h0007, {8'h0, scan});
    write_reg(7'h01, `LDS_CMD_DECODE, 8'h3F, 1'b1);
    check("decode", 16'h003F, {8'h0, decode});
    write_reg(7'h01, `LDS_CMD_DISPTST, 8'h01, 1'b1);
    check("disp test", 16'h0001, {8'h0, disp_test});
  endtask
  // Pointer set, repeated start, two bytes read
  task automatic t_read();
    logic k;
    logic [7:0] b0, b1;
    lds_bus_master_i.bus_start();
    lds_bus_master_i.send_byte(8'h02, k);
    lds_bus_master_i.send_byte(`LDS_CMD_DECODE, k);
    lds_bus_master_i.bus_start();
    lds_bus_master_i.send_byte(8'h03, k);
    check("read ack", 16'h0001, {15'h0, k});
    lds_bus_master_i.recv_byte(1'b0, b0);
    lds_bus_master_i.recv_byte(1'b1, b1);
    lds_bus_master_i.hold(4);
    check("read data", 16'hC3C3, {b0, b1});
    check("released", 16'h0000, {15'h0, sda_oe});
    lds_bus_master_i.bus_stop();
    check("pointer", {8'h0, `LDS_CMD_DECODE}, {8'h0, last_cmd});
  endtask
  // Supply loss mid-run: defaults return and the address is set afresh;
  // a second command with a changed node leaves the address alone
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_defaults();
    write_reg(7'h00, `LDS_CMD_SELFADR, 8'h00, 1'b1);
    check("addr again", 16'h0001, {9'h0, dev_addr});
    key_f = 1'b1;
    write_reg(7'h01, `LDS_CMD_SELFADR, 8'h00, 1'b1);
    check("addr once", 16'h0001, {9'h0, dev_addr});
    key_f = 1'b0;
  endtask
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    key_g = 1'b1;
    key_f = 1'b0;
    ready = 1'b0;
    rd_data = 8'hC3;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_defaults();
    t_fifo();
    t_shutdown();
    t_self_addr();
    t_read();
    t_reset();
    complete_run();
  end
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end
endmodule // test_lds_slave
`default_nettype wire
